// >>> bsf_pkg.sv
// Package for the bit, shift and flag instruction unit.
// Assumes a single core clock and an 8-bit data path.
package bsf_pkg;

    localparam int DATA_W = 8;
    localparam int IDX_W  = 3;
    localparam int IOA_W  = 6;
    localparam int OP_W   = 5;

    // Status register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] DATA_RST   = 8'h00;

    // Cycle counts
    localparam int IO_BIT_CYCLES = 2;
    localparam int ONE_CYCLE     = 1;

    // Operation codes from the decoder
    typedef enum logic [4:0] {
        BSF_NOP                       = 5'h00,
        BSF_IO_BIT_SET_OP             = 5'h01,
        BSF_IO_BIT_CLEAR_OP           = 5'h02,
        BSF_LOGICAL_LEFT_SHIFT_OP     = 5'h03,
        BSF_LOGICAL_RIGHT_SHIFT_OP    = 5'h04,
        BSF_ROTATE_LEFT_CARRY_OP      = 5'h05,
        BSF_ROTATE_RIGHT_CARRY_OP     = 5'h06,
        BSF_ARITH_RIGHT_SHIFT_OP      = 5'h07,
        BSF_NIBBLE_SWAP_OP            = 5'h08,
        BSF_FLAG_SET_GENERIC_OP       = 5'h09,
        BSF_FLAG_CLEAR_GENERIC_OP     = 5'h0A,
        BSF_BIT_TO_TRANSFER_FLAG_OP   = 5'h0B,
        BSF_TRANSFER_FLAG_TO_BIT_OP   = 5'h0C,
        BSF_CARRY_SET_OP              = 5'h0D,
        BSF_CARRY_CLEAR_OP            = 5'h0E,
        BSF_NEGATIVE_SET_OP           = 5'h0F,
        BSF_NEGATIVE_CLEAR_OP         = 5'h10,
        BSF_ZERO_SET_OP               = 5'h11
    } bsf_op_e;

    // I/O bit sequencer states
    typedef enum logic [1:0] {
        BSF_IO_IDLE  = 2'b00,
        BSF_IO_READ  = 2'b01,
        BSF_IO_WRITE = 2'b10
    } bsf_io_state_e;

endpackage

// >>> bsf_shifter.sv
// Combinational shift, rotate and swap unit with flag results.
// Assumes operands and carry are stable from the caller's registers.
`timescale 1ns/10ps
module bsf_shifter
    import bsf_pkg::*;
(
    input  wire logic [4:0] op_in,
    input  wire logic [7:0] operand_in,
    input  wire logic       carry_in,
    output logic      [7:0] result_out,
    output logic            carry_out,
    output logic            zero_out,
    output logic            neg_out,
    output logic            ovf_out,
    output logic            flags_upd_out
);
    import bsf_pkg::*;

    always_comb begin
        result_out    = operand_in;
        carry_out     = carry_in;
        flags_upd_out = 1'b1;
        unique case (bsf_op_e'(op_in))
            BSF_LOGICAL_LEFT_SHIFT_OP: begin
                result_out = {operand_in[6:0], 1'b0};
                carry_out  = operand_in[7];
            end
            BSF_LOGICAL_RIGHT_SHIFT_OP: begin
                result_out = {1'b0, operand_in[7:1]};
                carry_out  = operand_in[0];
            end
            BSF_ROTATE_LEFT_CARRY_OP: begin
                result_out = {operand_in[6:0], carry_in};
                carry_out  = operand_in[7];
            end
            BSF_ROTATE_RIGHT_CARRY_OP: begin
                result_out = {carry_in, operand_in[7:1]};
                carry_out  = operand_in[0];
            end
            BSF_ARITH_RIGHT_SHIFT_OP: begin
                result_out = {operand_in[7], operand_in[7:1]};
                carry_out  = operand_in[0];
            end
            BSF_NIBBLE_SWAP_OP: begin
                result_out    = {operand_in[3:0], operand_in[7:4]};
                flags_upd_out = 1'b0;
            end
            default: begin
                flags_upd_out = 1'b0;
            end
        endcase
        zero_out = (result_out == 8'h00);
        neg_out  = result_out[7];
        ovf_out  = result_out[7] ^ carry_out;
    end

endmodule

// >>> bsf_unit.sv
// Bit, shift and flag instruction execution unit.
// Assumes a decoder issues one operation strobe when busy_out and io_we_out are low,
// and an I/O space that answers a read in the same cycle that io_re_out is high.
// How it works
// - Set-I/O-bit forces the chosen I/O bit to one, keeps flags, and takes two cycles.
// - Clear-I/O-bit forces the chosen I/O bit to zero, keeps flags, and takes two cycles.
// - Logical left shift moves bits up, fills bit 0 with zero, and sets Z, C, N, V in one cycle.
// - Logical right shift moves bits down, fills bit 7 with zero, and sets Z, C, N, V in one cycle.
// - Rotate left puts old carry in bit 0 and old bit 7 in carry, and sets Z, N, V.
// - Rotate right puts old carry in bit 7 and old bit 0 in carry, and sets Z, N, V.
// - Arithmetic right shift keeps bit 7, shifts the rest down, and sets Z, C, N, V in one cycle.
// - Nibble swap exchanges the two halves in one cycle and leaves flags alone.
// - Generic flag set and clear write one or zero to the indexed status bit in one cycle.
// - Bit store copies the chosen source bit into the transfer flag in one cycle, nothing else.
// - Bit load copies the transfer flag into the chosen destination bit in one cycle.
// - Carry set and clear write carry only, in one cycle.
// - Negative set and clear write the negative flag only, in one cycle.
// - Zero set writes one to the zero flag only, in one cycle.
`timescale 1ns/10ps
module bsf_unit
    import bsf_pkg::*;
#(
    parameter int DATA_WIDTH = 8,
    parameter int IO_ADDR_WIDTH = 6
)
(
    input  wire logic                           clk_in,
    input  wire logic                           nrst_in,
    input  wire logic                           op_valid_in,
    input  wire logic [bsf_pkg::OP_W-1:0]       op_code_in,
    input  wire logic [bsf_pkg::IDX_W-1:0]      bit_index_in,
    input  wire logic [bsf_pkg::IDX_W-1:0]      flag_index_in,
    input  wire logic [4:0]                     dest_reg_in,
    input  wire logic [bsf_pkg::DATA_W-1:0]     dest_data_in,
    input  wire logic [bsf_pkg::DATA_W-1:0]     source_register_in,
    input  wire logic [bsf_pkg::IOA_W-1:0]      io_addr_in,
    input  wire logic [bsf_pkg::DATA_W-1:0]     io_rdata_in,
    output logic      [bsf_pkg::DATA_W-1:0]     status_register_out,
    output logic                                reg_we_out,
    output logic      [4:0]                     reg_addr_out,
    output logic      [bsf_pkg::DATA_W-1:0]     reg_wdata_out,
    output logic                                io_re_out,
    output logic                                io_we_out,
    output logic      [bsf_pkg::IOA_W-1:0]      io_addr_out,
    output logic      [bsf_pkg::DATA_W-1:0]     io_wdata_out,
    output logic                                busy_out,
    output logic                                done_out
);
    import bsf_pkg::*;

    initial begin
        if (DATA_WIDTH != DATA_W || IO_ADDR_WIDTH != IOA_W) begin
            $error("bsf_unit: only 8-bit data and 6-bit I/O address are supported");
        end
    end

    logic [7:0]    status_q;
    bsf_io_state_e io_state_q;
    logic [2:0]    io_bit_q;
    logic          io_set_q;
    logic [7:0]    bit_mask;
    logic [7:0]    flag_mask;
    logic [7:0]    io_mod;
    logic [7:0]    sh_result;
    logic          sh_carry;
    logic          sh_zero;
    logic          sh_neg;
    logic          sh_ovf;
    logic          sh_upd;
    logic          accept;
    bsf_op_e       op;

    assign op        = bsf_op_e'(op_code_in);
    assign accept    = op_valid_in && (io_state_q == BSF_IO_IDLE);
    assign bit_mask  = 8'h01 << bit_index_in;
    assign flag_mask = 8'h01 << flag_index_in;
    assign io_mod    = io_set_q ? (io_rdata_in | (8'h01 << io_bit_q))
                                : (io_rdata_in & ~(8'h01 << io_bit_q));

    bsf_shifter u_shifter (
        .op_in         (op_code_in),
        .operand_in    (dest_data_in),
        .carry_in      (status_q[FLAG_C]),
        .result_out    (sh_result),
        .carry_out     (sh_carry),
        .zero_out      (sh_zero),
        .neg_out       (sh_neg),
        .ovf_out       (sh_ovf),
        .flags_upd_out (sh_upd)
    );

    // Status register updates
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            status_q <= STATUS_RST;
        end else if (accept) begin
            if (sh_upd) begin
                status_q[FLAG_C] <= sh_carry;
                status_q[FLAG_Z] <= sh_zero;
                status_q[FLAG_N] <= sh_neg;
                status_q[FLAG_V] <= sh_ovf;
            end
            unique case (op)
                BSF_FLAG_SET_GENERIC_OP: status_q <= status_q | flag_mask;
                BSF_FLAG_CLEAR_GENERIC_OP: status_q <= status_q & ~flag_mask;
                BSF_BIT_TO_TRANSFER_FLAG_OP: begin
                    status_q[FLAG_T] <= source_register_in[bit_index_in];
                end
                BSF_CARRY_SET_OP: status_q[FLAG_C] <= 1'b1;
                BSF_CARRY_CLEAR_OP: status_q[FLAG_C] <= 1'b0;
                BSF_NEGATIVE_SET_OP: status_q[FLAG_N] <= 1'b1;
                BSF_NEGATIVE_CLEAR_OP: status_q[FLAG_N] <= 1'b0;
                BSF_ZERO_SET_OP: status_q[FLAG_Z] <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            status_register_out <= STATUS_RST;
        end else begin
            status_register_out <= status_q;
        end
    end

    // Working register write-back
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_we_out    <= 1'b0;
            reg_addr_out  <= 5'h00;
            reg_wdata_out <= DATA_RST;
        end else begin
            reg_we_out <= 1'b0;
            if (accept) begin
                reg_addr_out <= dest_reg_in;
                if (sh_upd || op == BSF_NIBBLE_SWAP_OP) begin
                    reg_we_out    <= 1'b1;
                    reg_wdata_out <= sh_result;
                end else if (op == BSF_TRANSFER_FLAG_TO_BIT_OP) begin
                    reg_we_out    <= 1'b1;
                    reg_wdata_out <= status_q[FLAG_T] ? (dest_data_in | bit_mask)
                                                     : (dest_data_in & ~bit_mask);
                end
            end
        end
    end

    // Two-cycle I/O read-modify-write sequencer
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            io_state_q   <= BSF_IO_IDLE;
            io_bit_q     <= 3'h0;
            io_set_q     <= 1'b0;
            io_re_out    <= 1'b0;
            io_we_out    <= 1'b0;
            io_addr_out  <= 6'h00;
            io_wdata_out <= DATA_RST;
            busy_out     <= 1'b0;
        end else begin
            io_re_out <= 1'b0;
            io_we_out <= 1'b0;
            unique case (io_state_q)
                BSF_IO_IDLE: begin
                    if (accept && (op == BSF_IO_BIT_SET_OP || op == BSF_IO_BIT_CLEAR_OP)) begin
                        io_state_q  <= BSF_IO_READ;
                        io_bit_q    <= bit_index_in;
                        io_set_q    <= (op == BSF_IO_BIT_SET_OP);
                        io_addr_out <= io_addr_in;
                        io_re_out   <= 1'b1;
                        busy_out    <= 1'b1;
                    end
                end
                BSF_IO_READ: begin
                    io_state_q   <= BSF_IO_WRITE;
                    io_we_out    <= 1'b1;
                    io_wdata_out <= io_mod;
                    busy_out     <= 1'b0;
                end
                BSF_IO_WRITE: begin
                    io_state_q <= BSF_IO_IDLE;
                end
                default: begin
                    io_state_q <= BSF_IO_IDLE;
                end
            endcase
        end
    end

    // Completion pulse
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= (accept && op != BSF_NOP && op != BSF_IO_BIT_SET_OP
                         && op != BSF_IO_BIT_CLEAR_OP) || (io_state_q == BSF_IO_READ);
        end
    end

endmodule

// >>> bsf_unit_properties.sv
// Port checker for the bit, shift and flag unit.
// Assumes the unit's own port names and one clock domain.
`timescale 1ns/10ps
module bsf_unit_properties
    import bsf_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       op_valid_in,
    input  wire logic [4:0] op_code_in,
    input  wire logic [2:0] bit_index_in,
    input  wire logic [7:0] dest_data_in,
    input  wire logic [7:0] source_register_in,
    input  wire logic [5:0] io_addr_in,
    input  wire logic [7:0] io_rdata_in,
    input  wire logic [7:0] status_register_out,
    input  wire logic       reg_we_out,
    input  wire logic [7:0] reg_wdata_out,
    input  wire logic       io_re_out,
    input  wire logic       io_we_out,
    input  wire logic [5:0] io_addr_out,
    input  wire logic [7:0] io_wdata_out,
    input  wire logic       busy_out,
    input  wire logic       done_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    wire go = op_valid_in && !busy_out && !io_we_out;

    property p_io_read;
        go && op_code_in inside {BSF_IO_BIT_SET_OP, BSF_IO_BIT_CLEAR_OP}
            |=> io_re_out && busy_out && io_addr_out == $past(io_addr_in);
    endproperty
    a_io_read: assert property (p_io_read) else $error("io read missing");
    property p_io_set;
        go && op_code_in == BSF_IO_BIT_SET_OP ##1 1'b1 |=> io_we_out && done_out &&
            io_wdata_out == ($past(io_rdata_in) | (8'h01 << $past(bit_index_in, 2)));
    endproperty
    a_io_set: assert property (p_io_set) else $error("io bit set wrong");
    property p_io_clr;
        go && op_code_in == BSF_IO_BIT_CLEAR_OP ##1 1'b1 |=> io_we_out && done_out &&
            io_wdata_out == ($past(io_rdata_in) & ~(8'h01 << $past(bit_index_in, 2)));
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong");
    property p_lsl;
        go && op_code_in == BSF_LOGICAL_LEFT_SHIFT_OP |=> (reg_we_out && reg_wdata_out ==
            {$past(dest_data_in[6:0]), 1'b0}) ##1 status_register_out[FLAG_C] == $past(dest_data_in[7], 2);
    endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong");
    property p_asr;
        go && op_code_in == BSF_ARITH_RIGHT_SHIFT_OP |=> (reg_wdata_out == {$past(dest_data_in[7]),
            $past(dest_data_in[7:1])}) ##1 status_register_out[FLAG_C] == $past(dest_data_in[0], 2);
    endproperty
    a_asr: assert property (p_asr) else $error("arith shift wrong");
    property p_ovf;
        go && op_code_in inside {[BSF_LOGICAL_LEFT_SHIFT_OP:BSF_ARITH_RIGHT_SHIFT_OP]} |=> ##1
            status_register_out[FLAG_V] == (status_register_out[FLAG_N] ^ status_register_out[FLAG_C])
            && status_register_out[FLAG_Z] == ($past(reg_wdata_out) == 8'h00)
            && status_register_out[FLAG_N] == $past(reg_wdata_out[7]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("shift flags wrong");
    property p_swap;
        go && op_code_in == BSF_NIBBLE_SWAP_OP |=> (reg_wdata_out == {$past(dest_data_in[3:0]),
            $past(dest_data_in[7:4])}) ##1 $stable(status_register_out);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");
    property p_bst;
        go && op_code_in == BSF_BIT_TO_TRANSFER_FLAG_OP
            |=> ##1 status_register_out[FLAG_T] == $past(source_register_in[bit_index_in], 2);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong");
    property p_carry_op;
        go && op_code_in inside {BSF_CARRY_SET_OP, BSF_CARRY_CLEAR_OP} |=> ##1
            status_register_out[FLAG_C] == ($past(op_code_in, 2) == BSF_CARRY_SET_OP);
    endproperty
    a_carry_op: assert property (p_carry_op) else $error("carry op wrong");
    property p_neg_op;
        go && op_code_in inside {BSF_NEGATIVE_SET_OP, BSF_NEGATIVE_CLEAR_OP} |=> ##1
            status_register_out[FLAG_N] == ($past(op_code_in, 2) == BSF_NEGATIVE_SET_OP);
    endproperty
    a_neg_op: assert property (p_neg_op) else $error("negative op wrong");
endmodule

bind bsf_unit bsf_unit_properties u_bsf_unit_properties (
    .clk_in, .nrst_in, .op_valid_in, .op_code_in, .bit_index_in, .dest_data_in,
    .source_register_in, .io_addr_in, .io_rdata_in, .status_register_out, .reg_we_out,
    .reg_wdata_out, .io_re_out, .io_we_out, .io_addr_out, .io_wdata_out, .busy_out, .done_out
);

// >>> test_bsf_unit.sv
// Self-checking bench for the bit, shift and flag unit.
// Drives decoder and I/O ports itself; the checker is bound in.
`timescale 1ns/10ps
module test_bsf_unit;
    import bsf_pkg::*;
    logic        clk_in, nrst_in, op_valid_in, reg_we_out, io_re_out, io_we_out, busy_out, done_out;
    logic [4:0]  op_code_in, dest_reg_in, reg_addr_out;
    logic [2:0]  bit_index_in, flag_index_in;
    logic [7:0]  dest_data_in, source_register_in, io_rdata_in, status_register_out;
    logic [7:0]  reg_wdata_out, io_wdata_out, status_register;
    logic [5:0]  io_addr_in, io_addr_out;
    logic [16:0] exp;
    int          n_mismatch, samples_checked, i;
    integer      seed = 32'h0742;

    bsf_unit u_bsf_unit (.clk_in, .nrst_in, .op_valid_in, .op_code_in, .bit_index_in,
        .flag_index_in, .dest_reg_in, .dest_data_in, .source_register_in, .io_addr_in,
        .io_rdata_in, .status_register_out, .reg_we_out, .reg_addr_out, .reg_wdata_out,
        .io_re_out, .io_we_out, .io_addr_out, .io_wdata_out, .busy_out, .done_out);

    function automatic logic [16:0] model(input logic [4:0] op, input logic [7:0] d, s,
                                          input logic [2:0] bi, fi, input logic [7:0] sr);
        logic [7:0] r;
        logic [7:0] f;
        r = d;
        f = sr;
        case (op)
            5'h03: {f[0], r} = {d, 1'b0};
            5'h04: {r, f[0]} = {1'b0, d};
            5'h05: {f[0], r} = {d, sr[0]};
            5'h06: {r, f[0]} = {sr[0], d};
            5'h07: {r, f[0]} = {d[7], d};
            5'h08: r = {d[3:0], d[7:4]};
            5'h09, 5'h0A: f[fi] = (op == 5'h09);
            5'h0B: f[6] = s[bi];
            5'h0C: r[bi] = sr[6];
            5'h0D, 5'h0E: f[0] = (op == 5'h0D);
            5'h0F, 5'h10: f[2] = (op == 5'h0F);
            5'h11: f[1] = 1'b1;
            default: ;
        endcase
        if (op inside {[5'h03:5'h07]}) begin
            f[1] = (r == 8'h00);
            f[2] = r[7];
            f[3] = r[7] ^ f[0];
        end
        return {op inside {[5'h03:5'h08], 5'h0C}, f, r};
    endfunction

    task automatic check(input logic [7:0] got, want, input string what);
        samples_checked++;
        if (got !== want) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic end_of_test;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic run_op(input logic [4:0] op, input logic [7:0] d);
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_code_in <= op;
        dest_data_in <= d;
        source_register_in <= 8'($random(seed));
        {bit_index_in, flag_index_in, dest_reg_in} <= 11'($random(seed));
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        exp = model(op, d, source_register_in, bit_index_in, flag_index_in, status_register);
        status_register = exp[15:8];
        #1;
        check({reg_we_out, done_out}, {exp[16], 1'b1}, "strobes");
        if (exp[16]) check(reg_wdata_out, exp[7:0], "result");
        if (exp[16]) check(reg_addr_out, dest_reg_in, "dest");
        @(posedge clk_in);
        #1;
        check(status_register_out, status_register, "status");
    endtask

    task automatic io_op(input logic set, input logic [7:0] rd);
        logic [7:0] want;
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_code_in <= set ? BSF_IO_BIT_SET_OP : BSF_IO_BIT_CLEAR_OP;
        {io_addr_in, bit_index_in} <= 9'($random(seed));
        io_rdata_in <= rd;
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        want = set ? (rd | (8'h01 << bit_index_in)) : (rd & ~(8'h01 << bit_index_in));
        #1;
        check({io_re_out, busy_out, io_addr_out}, {2'b11, io_addr_in}, "io read");
        @(posedge clk_in);
        io_rdata_in <= ~rd;
        #1;
        check(io_wdata_out, want, "io write");
        check({io_we_out, done_out, busy_out}, 3'b110, "io strobes");
        check(status_register_out, status_register, "io flags");
        @(posedge clk_in);
    endtask

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        end_of_test;
    end

    initial begin
        nrst_in = 1'b0;
        status_register = STATUS_RST;
        {op_valid_in, op_code_in, bit_index_in, flag_index_in, dest_reg_in} = '0;
        {dest_data_in, source_register_in, io_addr_in, io_rdata_in} = '0;
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        #1;
        check(status_register_out, STATUS_RST, "reset status");
        run_op(5'h03, 8'h81);
        run_op(5'h04, 8'h01);
        run_op(5'h05, 8'h80);
        run_op(5'h06, 8'h00);
        run_op(5'h07, 8'h80);
        for (i = 0; i < 300; i++) run_op(5'(3 + i % 15), 8'($random(seed)));
        for (i = 0; i < 16; i++) io_op(i[0], 8'($random(seed)));
        for (i = 0; i < 60; i++) begin
            @(posedge clk_in);
            op_valid_in <= 1'b1;
            op_code_in <= 5'(3 + {$random(seed)} % 15);
            {dest_data_in, source_register_in, bit_index_in} <= 19'($random(seed));
        end
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        end_of_test;
    end
endmodule
